// File: verilog/iocfg_pkg.sv
/*
  Constants, field positions, reset values, enumerations and carrier structs of the
  configuration register bank of a multi-function I/O chip. Shared by the register bank
  and by anything that decodes its outputs; it assumes a 200 MHz core clock.
*/
`default_nettype none
package iocfg_pkg;
  // Register indices behind the index/data pair.
  localparam logic [7:0] IDX_FAR = 8'h01;
  localparam logic [7:0] IDX_PTR = 8'h02;
  localparam logic [7:0] IDX_FCR = 8'h03;
  localparam logic [7:0] IDX_PCR = 8'h04;
  localparam logic [7:0] IDX_PMC = 8'h06;
  // Default I/O addresses of the index and data ports (strap dependent).
  localparam logic [15:0] INDEX_ADDR_DEF = 16'h002E;
  localparam logic [15:0] DATA_ADDR_DEF = 16'h002F;
  // Reset values.
  localparam logic [7:0] FAR_RST = 8'h00;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] FCR_RST = 8'h00;
  localparam logic [7:0] PCR_RST = 8'h00;
  localparam logic [7:0] FCR_RD_MASK = 8'hFD;
  // Power-and-test register fields.
  localparam int PTR_SWPD = 0;
  localparam int PTR_XTAL = 1;
  localparam int PTR_PRINTER_WINDOW_B_IRQ7 = 3;
  localparam int PTR_TEST1 = 4;
  localparam int PTR_TEST2 = 5;
  localparam int PTR_LOCK = 6;
  localparam int PTR_EXT = 7;
  // Function-control register fields.
  localparam int FCR_RATE = 0;
  localparam int FCR_PPM = 2;
  localparam int FCR_FLOAT = 3;
  localparam int FCR_SWAP = 4;
  localparam int FCR_ZWS = 5;
  localparam int FCR_POWER_DOWN_PIN_SEL = 6;
  localparam int FCR_MFM_SEL = 7;
  // Printer-control register fields.
  localparam int PCR_EPP = 0;
  localparam int PCR_EPP_V19 = 1;
  localparam int PCR_ECP = 2;
  localparam int PCR_ECP_CLK = 3;
  localparam int PCR_INV = 5;
  localparam int PCR_OD = 6;
  // Power-management register field kept here: the selective lock.
  localparam int PMC_SLOCK = 5;
  // Blocked input values {busy, paper_end, select, ack, error}.
  localparam logic [4:0] PPM_BLOCKED = 5'h13;
  // Serial port windows.
  localparam logic [9:0] COM1_BASE = 10'h3F8;
  localparam logic [9:0] COM2_BASE = 10'h2F8;
  localparam logic [9:0] COM3_B0 = 10'h3E8;
  localparam logic [9:0] COM3_B1 = 10'h338;
  localparam logic [9:0] COM3_B2 = 10'h2E8;
  localparam logic [9:0] COM3_B3 = 10'h220;
  localparam logic [9:0] COM4_B0 = 10'h2E8;
  localparam logic [9:0] COM4_B1 = 10'h238;
  localparam logic [9:0] COM4_B2 = 10'h2E0;
  localparam logic [9:0] COM4_B3 = 10'h228;
  // Printer window code that has no address and no interrupt.
  localparam logic [1:0] LPT_RESERVED = 2'h3;
  localparam logic [1:0] LPT_WINDOW_B = 2'h0;
  localparam logic [1:0] LPT_WINDOW_A = 2'h1;
  // Oscillator settle time in ms and the derived cycle count.
  localparam int STAB_MS = 8;
  localparam int CLK_MHZ = 200;
  localparam int STAB_CYCLES = STAB_MS * 1000 * CLK_MHZ;
  localparam int STAB_CNT_W = 21;

  typedef enum logic [2:0] {
    IOCFG_PAR_NONE = 3'h0,
    IOCFG_PAR_COMPAT = 3'h1,
    IOCFG_PAR_EXT = 3'h3,
    IOCFG_PAR_EPP = 3'h2,
    IOCFG_PAR_ECP = 3'h6
  } iocfg_par_mode_e;

  typedef enum logic [1:0] {
    IOCFG_PW_RUN = 2'h0,
    IOCFG_PW_XTAL = 2'h1,
    IOCFG_PW_SETTLE = 2'h3,
    IOCFG_PW_CLKS = 2'h2
  } iocfg_pwr_e;

  typedef struct packed {
    iocfg_par_mode_e mode;
    logic access_en;
    logic irq7_sel;
    logic level_irq;
    logic dir_by_ctrl;
    logic epp_v19;
    logic epp_access_en;
    logic ecp_access_en;
  } iocfg_par_cfg_s;

  typedef struct packed {
    logic drive0_select;
    logic drive1_select;
    logic motor0_on;
    logic motor1_on;
  } iocfg_drive_s;
endpackage
`default_nettype wire

// File: verilog/iocfg_regs.sv
/*
  Configuration register bank reached through an index/data port pair on the I/O bus,
  with the pin, mode and power-down controls that the registers steer.
  Assumes I/O strobes and pin inputs are synchronous to i_clk.
*/
`default_nettype none
module iocfg_regs #(
  parameter logic [15:0] INDEX_ADDR = iocfg_pkg::INDEX_ADDR_DEF,
  parameter logic [15:0] DATA_ADDR = iocfg_pkg::DATA_ADDR_DEF,
  parameter int STAB_CYCLES = iocfg_pkg::STAB_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [15:0] i_addr,
  input wire logic i_ior_b,
  input wire logic i_iow_b,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe,
  input wire logic i_par_func_en,
  input wire logic i_power_down_pin_b,
  input wire logic i_rate_strap_pin,
  input wire logic i_lcr7_1,
  input wire logic i_lcr7_2,
  input wire logic i_baud1,
  input wire logic i_baud2,
  input wire logic i_uart1_sout,
  input wire logic i_uart2_sout,
  input wire iocfg_pkg::iocfg_drive_s i_fdc_drive,
  input wire logic [4:0] i_ppm_status,
  input wire logic i_short_cycle_ok,
  input wire logic i_epp_extend,
  input wire logic i_par_irq,
  input wire logic i_ecp_irq,
  input wire logic i_ecp_dma_req,
  output logic [9:0] o_uart2_base,
  output logic [9:0] o_com3_base,
  output logic [9:0] o_com4_base,
  output logic o_clocks_stop,
  output logic o_crystal_stop,
  output logic o_func_ready,
  output logic o_ecp_clk_run,
  output logic o_serial1_out,
  output logic o_serial2_out,
  output iocfg_pkg::iocfg_par_cfg_s o_par_cfg,
  output logic o_data_rate_outputs,
  output logic o_tape_bits_float,
  output logic o_floppy_on_port,
  output logic o_ppm_float,
  output logic [4:0] o_ppm_status,
  output iocfg_pkg::iocfg_drive_s o_drive,
  output logic o_zero_wait_out,
  output logic o_zero_wait_out_oe,
  output logic o_chip_select_opt,
  output logic o_mfm_opt,
  output logic o_iochrdy,
  output logic o_iochrdy_oe,
  output logic o_par_irq,
  output logic o_par_irq_oe,
  output logic o_irq_inputs_block,
  output logic o_dma_req,
  output logic o_dma_req_oe
);
  if (STAB_CYCLES < 1 || STAB_CYCLES >= 2 ** iocfg_pkg::STAB_CNT_W) begin : g_bad_stab
    $error("STAB_CYCLES does not fit the settle counter.");
  end

  // Window lookup shared by the second serial port and the COM3/COM4 outputs.
  function automatic logic [9:0] com_window(input logic [1:0] com, input logic [1:0] place);
    logic [9:0] b3;
    logic [9:0] b4;
    b3 = iocfg_pkg::COM3_B0;
    b4 = iocfg_pkg::COM4_B0;
    unique case (place)
      2'h0: begin
        b3 = iocfg_pkg::COM3_B0;
        b4 = iocfg_pkg::COM4_B0;
      end
      2'h1: begin
        b3 = iocfg_pkg::COM3_B1;
        b4 = iocfg_pkg::COM4_B1;
      end
      2'h2: begin
        b3 = iocfg_pkg::COM3_B2;
        b4 = iocfg_pkg::COM4_B2;
      end
      2'h3: begin
        b3 = iocfg_pkg::COM3_B3;
        b4 = iocfg_pkg::COM4_B3;
      end
    endcase
    unique case (com)
      2'h0: com_window = iocfg_pkg::COM1_BASE;
      2'h1: com_window = iocfg_pkg::COM2_BASE;
      2'h2: com_window = b3;
      2'h3: com_window = b4;
    endcase
  endfunction

  logic [7:0] index;
  logic [7:0] function_address;
  logic [7:0] ptr;
  logic [7:0] function_control;
  logic [7:0] printer_control;
  logic pmc_slock;
  logic strap_taken;
  logic iow_prev;
  logic wr_pulse;
  logic idx_wr;
  logic data_wr;
  logic lock_all;
  logic pd_req;
  iocfg_pkg::iocfg_pwr_e pwr_state;
  iocfg_pkg::iocfg_pwr_e next_pwr_state;
  logic [iocfg_pkg::STAB_CNT_W-1:0] settle_cnt;
  iocfg_pkg::iocfg_par_mode_e next_mode;
  logic [7:0] next_rdata;
  logic next_irq_level;

  // Writes act once, on the leading edge of the write strobe.
  assign wr_pulse = !i_iow_b && iow_prev;
  assign idx_wr = wr_pulse && (i_addr == INDEX_ADDR);
  assign data_wr = wr_pulse && (i_addr == DATA_ADDR) && !lock_all;
  assign lock_all = ptr[iocfg_pkg::PTR_LOCK];
  assign pd_req = ptr[iocfg_pkg::PTR_SWPD] || !i_power_down_pin_b;

  // Strobe history and index register; the index port is not locked.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      iow_prev <= 1'b1;
      index <= 8'h00;
    end else begin
      iow_prev <= i_iow_b;
      if (idx_wr) begin
        index <= i_data;
      end
    end
  end

  // Function address register.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      function_address <= iocfg_pkg::FAR_RST;
    end else if (data_wr && index == iocfg_pkg::IDX_FAR && !pmc_slock) begin
      function_address <= i_data;
    end
  end

  // Power and test register; the lock bit can only be cleared by reset.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ptr <= iocfg_pkg::PTR_RST;
    end else if (data_wr && index == iocfg_pkg::IDX_PTR) begin
      ptr <= i_data;
      if (pmc_slock) begin
        ptr[3:2] <= ptr[3:2];
      end
    end
  end

  // Function control register with the rate strap caught just after reset release.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      function_control <= iocfg_pkg::FCR_RST;
      strap_taken <= 1'b0;
    end else begin
      strap_taken <= 1'b1;
      if (!strap_taken) begin
        function_control[iocfg_pkg::FCR_RATE] <= i_rate_strap_pin;
      end else if (data_wr && index == iocfg_pkg::IDX_FCR) begin
        function_control <= i_data & iocfg_pkg::FCR_RD_MASK;
        if (pmc_slock) begin
          function_control[7:6] <= function_control[7:6];
        end
      end
    end
  end

  // Printer control register.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      printer_control <= iocfg_pkg::PCR_RST;
    end else if (data_wr && index == iocfg_pkg::IDX_PCR) begin
      printer_control <= i_data;
    end
  end

  // Selective lock bit: sticky until reset.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pmc_slock <= 1'b0;
    end else if (data_wr && index == iocfg_pkg::IDX_PMC && i_data[iocfg_pkg::PMC_SLOCK]) begin
      pmc_slock <= 1'b1;
    end
  end

  // Read mux; reads are never blocked by either lock.
  always_comb begin
    next_rdata = 8'h00;
    if (i_addr == INDEX_ADDR) begin
      next_rdata = index;
    end else begin
      unique case (index)
        iocfg_pkg::IDX_FAR: next_rdata = function_address;
        iocfg_pkg::IDX_PTR: next_rdata = ptr;
        iocfg_pkg::IDX_FCR: next_rdata = function_control;
        iocfg_pkg::IDX_PCR: next_rdata = printer_control;
        iocfg_pkg::IDX_PMC: next_rdata = {2'h0, pmc_slock, 5'h00};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Read data flops; the bus is driven while the read strobe is low at a hit.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_data <= 8'h00;
      o_data_oe <= 1'b0;
    end else begin
      o_data <= next_rdata;
      o_data_oe <= !i_ior_b && (i_addr == INDEX_ADDR || i_addr == DATA_ADDR);
    end
  end

  // Power-down sequencing. A crystal stop is followed by a settle wait; a clock stop
  // resumes at once because the oscillator never stopped.
  always_comb begin
    next_pwr_state = pwr_state;
    unique case (pwr_state)
      iocfg_pkg::IOCFG_PW_RUN: begin
        if (pd_req && ptr[iocfg_pkg::PTR_XTAL]) begin
          next_pwr_state = iocfg_pkg::IOCFG_PW_XTAL;
        end else if (pd_req) begin
          next_pwr_state = iocfg_pkg::IOCFG_PW_CLKS;
        end
      end
      iocfg_pkg::IOCFG_PW_XTAL: begin
        if (!pd_req) begin
          next_pwr_state = iocfg_pkg::IOCFG_PW_SETTLE;
        end
      end
      iocfg_pkg::IOCFG_PW_SETTLE: begin
        if (settle_cnt == iocfg_pkg::STAB_CNT_W'(STAB_CYCLES - 1)) begin
          next_pwr_state = iocfg_pkg::IOCFG_PW_RUN;
        end
      end
      iocfg_pkg::IOCFG_PW_CLKS: begin
        if (!pd_req) begin
          next_pwr_state = iocfg_pkg::IOCFG_PW_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pwr_state <= iocfg_pkg::IOCFG_PW_RUN;
      settle_cnt <= '0;
    end else begin
      pwr_state <= next_pwr_state;
      if (pwr_state == iocfg_pkg::IOCFG_PW_SETTLE) begin
        settle_cnt <= settle_cnt + 1'b1;
      end else begin
        settle_cnt <= '0;
      end
    end
  end

  // Parallel mode decode; reserved control combinations fall back to the plain modes.
  always_comb begin
    next_mode = iocfg_pkg::IOCFG_PAR_NONE;
    if (!i_par_func_en) begin
      next_mode = iocfg_pkg::IOCFG_PAR_NONE;
    end else if (printer_control[iocfg_pkg::PCR_EPP] && !printer_control[iocfg_pkg::PCR_ECP]) begin
      next_mode = iocfg_pkg::IOCFG_PAR_EPP;
    end else if (!printer_control[iocfg_pkg::PCR_EPP] && printer_control[iocfg_pkg::PCR_ECP]) begin
      next_mode = iocfg_pkg::IOCFG_PAR_ECP;
    end else if (ptr[iocfg_pkg::PTR_EXT]) begin
      next_mode = iocfg_pkg::IOCFG_PAR_EXT;
    end else begin
      next_mode = iocfg_pkg::IOCFG_PAR_COMPAT;
    end
  end

  // Interrupt level before the pin driver; ECP interrupt stays idle when ECP is off.
  // ECP interrupt gated
  assign next_irq_level = (i_par_irq || (printer_control[iocfg_pkg::PCR_ECP] && i_ecp_irq))
    ^ printer_control[iocfg_pkg::PCR_INV];

  // Address windows and parallel configuration flops.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_uart2_base <= iocfg_pkg::COM1_BASE;
      o_com3_base <= iocfg_pkg::COM3_B0;
      o_com4_base <= iocfg_pkg::COM4_B0;
      o_par_cfg <= '0;
    end else begin
      o_uart2_base <= com_window(function_address[5:4], function_address[7:6]);
      o_com3_base <= com_window(2'h2, function_address[7:6]);
      o_com4_base <= com_window(2'h3, function_address[7:6]);
      o_par_cfg.mode <= next_mode;
      o_par_cfg.access_en <= i_par_func_en && function_address[1:0] != iocfg_pkg::LPT_RESERVED;
      o_par_cfg.irq7_sel <= function_address[1:0] == iocfg_pkg::LPT_WINDOW_A
        || (function_address[1:0] == iocfg_pkg::LPT_WINDOW_B && ptr[iocfg_pkg::PTR_PRINTER_WINDOW_B_IRQ7]);
      // level interrupts only in extended mode
      o_par_cfg.level_irq <= next_mode == iocfg_pkg::IOCFG_PAR_EXT;
      o_par_cfg.dir_by_ctrl <= next_mode == iocfg_pkg::IOCFG_PAR_EPP && ptr[iocfg_pkg::PTR_EXT];
      o_par_cfg.epp_v19 <= printer_control[iocfg_pkg::PCR_EPP_V19];
      o_par_cfg.epp_access_en <= next_mode == iocfg_pkg::IOCFG_PAR_EPP;
      o_par_cfg.ecp_access_en <= next_mode == iocfg_pkg::IOCFG_PAR_ECP;
    end
  end

  // Power-down outputs. The register bank itself keeps its contents throughout.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_clocks_stop <= 1'b0;
      o_crystal_stop <= 1'b0;
      o_func_ready <= 1'b1;
      o_ecp_clk_run <= 1'b1;
    end else begin
      o_clocks_stop <= next_pwr_state != iocfg_pkg::IOCFG_PW_RUN
        && next_pwr_state != iocfg_pkg::IOCFG_PW_SETTLE;
      o_crystal_stop <= next_pwr_state == iocfg_pkg::IOCFG_PW_XTAL;
      o_func_ready <= next_pwr_state == iocfg_pkg::IOCFG_PW_RUN;
      o_ecp_clk_run <= next_pwr_state == iocfg_pkg::IOCFG_PW_RUN || printer_control[iocfg_pkg::PCR_ECP_CLK];
    end
  end

  // Pin role and pin driver flops.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_serial1_out <= 1'b1;
      o_serial2_out <= 1'b1;
      o_data_rate_outputs <= 1'b0;
      o_tape_bits_float <= 1'b0;
      o_floppy_on_port <= 1'b0;
      o_ppm_float <= 1'b0;
      o_ppm_status <= iocfg_pkg::PPM_BLOCKED;
      o_drive <= '0;
      o_zero_wait_out_oe <= 1'b0;
      o_chip_select_opt <= 1'b0;
      o_mfm_opt <= 1'b0;
      o_iochrdy_oe <= 1'b0;
      o_par_irq <= 1'b0;
      o_par_irq_oe <= 1'b0;
      o_irq_inputs_block <= 1'b1;
      o_dma_req <= 1'b0;
      o_dma_req_oe <= 1'b0;
    end else begin
      o_serial1_out <= (ptr[iocfg_pkg::PTR_TEST1] && i_lcr7_1) ? i_baud1 : i_uart1_sout;
      o_serial2_out <= (ptr[iocfg_pkg::PTR_TEST2] && i_lcr7_2) ? i_baud2 : i_uart2_sout;
      o_data_rate_outputs <= function_control[iocfg_pkg::FCR_RATE];
      o_tape_bits_float <= function_control[iocfg_pkg::FCR_RATE];
      o_floppy_on_port <= function_control[iocfg_pkg::FCR_PPM];
      o_ppm_float <= function_control[iocfg_pkg::FCR_FLOAT];
      o_ppm_status <= function_control[iocfg_pkg::FCR_FLOAT] ? iocfg_pkg::PPM_BLOCKED : i_ppm_status;
      if (function_control[iocfg_pkg::FCR_SWAP]) begin
        o_drive <= {i_fdc_drive.drive1_select, i_fdc_drive.drive0_select,
                    i_fdc_drive.motor1_on, i_fdc_drive.motor0_on};
      end else begin
        o_drive <= i_fdc_drive;
      end
      o_zero_wait_out_oe <= function_control[iocfg_pkg::FCR_ZWS] && !function_control[iocfg_pkg::FCR_POWER_DOWN_PIN_SEL]
        && i_short_cycle_ok && (next_mode == iocfg_pkg::IOCFG_PAR_EPP
        || next_mode == iocfg_pkg::IOCFG_PAR_ECP);
      o_chip_select_opt <= function_control[iocfg_pkg::FCR_POWER_DOWN_PIN_SEL];
      o_mfm_opt <= function_control[iocfg_pkg::FCR_MFM_SEL];
      o_iochrdy_oe <= !function_control[iocfg_pkg::FCR_MFM_SEL] && i_epp_extend;
      if (printer_control[iocfg_pkg::PCR_OD]) begin
        o_par_irq <= 1'b0;
        o_par_irq_oe <= o_par_cfg.access_en && !next_irq_level;
      end else begin
        o_par_irq <= next_irq_level;
        o_par_irq_oe <= o_par_cfg.access_en;
      end
      o_irq_inputs_block <= !printer_control[iocfg_pkg::PCR_ECP];
      o_dma_req <= i_ecp_dma_req;
      o_dma_req_oe <= next_mode == iocfg_pkg::IOCFG_PAR_ECP;
    end
  end

  // Open-drain pins only ever pull low.
  assign o_zero_wait_out = 1'b0;
  assign o_iochrdy = 1'b0;

  // Checks on the register bank and the pins it steers.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_locked_write;
    wr_pulse && i_addr == DATA_ADDR && lock_all;
  endsequence

  sequence s_xtal_release;
    pwr_state == iocfg_pkg::IOCFG_PW_XTAL && !pd_req;
  endsequence

  property p_global_lock;
    s_locked_write |=> $stable(function_address) && $stable(ptr) && $stable(function_control) && $stable(printer_control);
  endproperty
  a_global_lock: assert property (p_global_lock) else $error("Locked write changed a register.");

  property p_settle_hold;
    s_xtal_release |=> !o_func_ready [*8];
  endproperty
  a_settle_hold: assert property (p_settle_hold) else $error("Ready before settle.");

  property p_clk_resume;
    pwr_state == iocfg_pkg::IOCFG_PW_CLKS && !pd_req |=> o_func_ready && !o_clocks_stop;
  endproperty
  a_clk_resume: assert property (p_clk_resume) else $error("Clock stop resume delayed.");

  property p_xtal_stop;
    pwr_state == iocfg_pkg::IOCFG_PW_RUN && pd_req && ptr[iocfg_pkg::PTR_XTAL]
      |=> o_crystal_stop && o_clocks_stop;
  endproperty
  a_xtal_stop: assert property (p_xtal_stop) else $error("Crystal stop not taken.");

  property p_uart2_base;
    ##1 o_uart2_base == com_window($past(function_address[5:4]), $past(function_address[7:6]));
  endproperty
  a_uart2_base: assert property (p_uart2_base) else $error("Second port window wrong.");

  property p_printer_window_b_irq7;
    function_address[1:0] == iocfg_pkg::LPT_WINDOW_B |=> o_par_cfg.irq7_sel == $past(ptr[3]);
  endproperty
  a_printer_window_b_irq7: assert property (p_printer_window_b_irq7) else $error("Window b interrupt wrong.");

  property p_test_mode;
    ptr[iocfg_pkg::PTR_TEST1] && i_lcr7_1 |=> o_serial1_out == $past(i_baud1);
  endproperty
  a_test_mode: assert property (p_test_mode) else $error("Baud clock not on serial out.");

  property p_swap;
    function_control[iocfg_pkg::FCR_SWAP] |=> o_drive.drive0_select == $past(i_fdc_drive.drive1_select);
  endproperty
  a_swap: assert property (p_swap) else $error("Drive swap not applied.");

  property p_epp_gate;
    !printer_control[iocfg_pkg::PCR_EPP] |=> !o_par_cfg.epp_access_en;
  endproperty
  a_epp_gate: assert property (p_epp_gate) else $error("EPP open while disabled.");

  property p_irq_od;
    printer_control[iocfg_pkg::PCR_OD] |=> !o_par_irq;
  endproperty
  a_irq_od: assert property (p_irq_od) else $error("Open-drain interrupt drove high.");
endmodule // iocfg_regs
`default_nettype wire

// File: verif/iocfg_host.sv
/*
  Host model that drives the index/data port pair of the register bank.
  Assumes the bank samples strobes on the rising edge of i_clk.
*/
`default_nettype none
module iocfg_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rd,
  output logic [15:0] o_addr,
  output logic o_ior_b,
  output logic o_iow_b,
  output logic [7:0] o_wd
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus idle at time zero.
  initial begin
    o_addr = 16'h0000;
    o_wd = 8'h00;
    {o_ior_b, o_iow_b} = 2'h3;
  end
  // One strobe cycle; data is inverted after release so stale bytes never match.
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wd <= d;
    o_iow_b <= 1'b0;
    @(posedge i_clk);
    o_iow_b <= 1'b1;
    o_wd <= ~d;
  endtask
  // Index first, then data, with the strobe high in between.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    put(iocfg_pkg::INDEX_ADDR_DEF, idx);
    put(iocfg_pkg::DATA_ADDR_DEF, d);
  endtask
  // Read data is registered, so it is taken two edges into the strobe.
  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    put(iocfg_pkg::INDEX_ADDR_DEF, idx);
    @(posedge i_clk);
    o_addr <= iocfg_pkg::DATA_ADDR_DEF;
    o_ior_b <= 1'b0;
    repeat (2) @(posedge i_clk);
    d = i_rd;
    o_ior_b <= 1'b1;
  endtask
endmodule // iocfg_host
`default_nettype wire

// File: verif/iocfg_regs_test.sv
/*
  Self-checking bench of the register bank, built on host model calls.
  Assumes the package, the bank and the host model are compiled first.
*/
`default_nettype none
module iocfg_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst_b, i_ior_b, i_iow_b, i_par_func_en, i_rate_strap_pin;
  logic i_power_down_pin_b, i_lcr7_1, i_lcr7_2, i_baud1, i_baud2;
  logic i_uart1_sout, i_uart2_sout, i_short_cycle_ok, i_epp_extend;
  logic i_par_irq, i_ecp_irq, i_ecp_dma_req, o_data_oe;
  logic [15:0] i_addr;
  logic [7:0] i_data, o_data, v;
  logic [4:0] i_ppm_status, o_ppm_status;
  logic [9:0] o_uart2_base, o_com3_base, o_com4_base;
  iocfg_pkg::iocfg_drive_s i_fdc_drive, o_drive;
  iocfg_pkg::iocfg_par_cfg_s o_par_cfg;
  logic o_clocks_stop, o_crystal_stop, o_func_ready, o_ecp_clk_run;
  logic o_serial1_out, o_serial2_out, o_data_rate_outputs, o_tape_bits_float;
  logic o_floppy_on_port, o_ppm_float, o_zero_wait_out, o_zero_wait_out_oe;
  logic o_chip_select_opt, o_mfm_opt, o_iochrdy, o_iochrdy_oe, o_par_irq;
  logic o_par_irq_oe, o_irq_inputs_block, o_dma_req, o_dma_req_oe;
  logic [9:0] c3[4] = '{10'h3E8, 10'h338, 10'h2E8, 10'h220};
  logic [9:0] c4[4] = '{10'h2E8, 10'h238, 10'h2E0, 10'h228};
  logic [9:0] u2[4] = '{10'h3F8, 10'h2F8, 10'h2E8, 10'h228};
  logic [18:0] md[3] = '{19'h20001, 19'h60004, 19'h38000};
  int n_fail = 0;
  int comparisons = 0;
  // A short settle count keeps the crystal restart visible in a brief run.
  iocfg_regs #(.STAB_CYCLES(20)) iocfg_regs_i (.*);
  iocfg_host iocfg_host_i (.i_clk(i_clk), .i_rd(o_data), .o_addr(i_addr),
    .o_ior_b(i_ior_b), .o_iow_b(i_iow_b), .o_wd(i_data));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Registered outputs settle two edges after the data write.
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    iocfg_host_i.wr(a, d);
    repeat (2) @(posedge i_clk);
  endtask
  task automatic r(input logic [7:0] a, input logic [7:0] e);
    iocfg_host_i.rd(a, v);
    chk(v, e);
  endtask
  // Free-running 200 MHz clock.
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // Global limit so a hang still reaches the verdict.
  initial begin
    #50000;
    n_fail++;
    wrap_up();
  end
  // Main sequence.
  initial begin
    i_rst_b = 1'b0;
    {i_par_func_en, i_rate_strap_pin, i_lcr7_1, i_lcr7_2, i_baud1, i_baud2} = 6'h30;
    {i_uart1_sout, i_uart2_sout, i_short_cycle_ok, i_epp_extend} = 4'h0;
    {i_par_irq, i_ecp_irq, i_ecp_dma_req, i_power_down_pin_b} = 4'h1;
    i_ppm_status = 5'h00;
    i_fdc_drive = 4'hA;
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    r(iocfg_pkg::IDX_PCR, 8'h00);
    r(iocfg_pkg::IDX_PTR, 8'h00);
    chk(o_par_cfg.mode, 16'h0001);
    chk({o_data_rate_outputs, o_tape_bits_float}, 16'h0003);
    for (int i = 0; i < 4; i++) begin
      w(iocfg_pkg::IDX_FAR, 8'(i * 8'h50));
      chk(o_com3_base, c3[i]);
      chk(o_com4_base, c4[i]);
      chk(o_uart2_base, u2[i]);
    end
    w(iocfg_pkg::IDX_FCR, 8'h1C);
    chk(o_drive, 16'h0005);
    chk(o_ppm_status, 16'h0013);
    chk(o_floppy_on_port, 16'h0001);
    chk(o_ppm_float, 16'h0001);
    r(iocfg_pkg::IDX_FCR, 8'h1C);
    for (int i = 0; i < 3; i++) begin
      w(iocfg_pkg::IDX_PTR, md[i][15:8]);
      w(iocfg_pkg::IDX_PCR, md[i][7:0]);
      chk(o_par_cfg.mode, md[i][18:16]);
    end
    i_short_cycle_ok <= 1'b1;
    chk(o_par_cfg.level_irq, 16'h0001);
    chk({o_irq_inputs_block, o_dma_req_oe}, 16'h0002);
    w(iocfg_pkg::IDX_PCR, 8'h01);
    chk(o_par_cfg.dir_by_ctrl, 16'h0001);
    w(iocfg_pkg::IDX_FCR, 8'h20);
    chk(o_zero_wait_out_oe, 16'h0001);
    w(iocfg_pkg::IDX_FCR, 8'hC0);
    chk({o_chip_select_opt, o_mfm_opt}, 16'h0003);
    w(iocfg_pkg::IDX_PCR, 8'h62);
    chk({o_par_irq, o_par_irq_oe}, 16'h0000);
    chk(o_par_cfg.epp_v19, 16'h0001);
    w(iocfg_pkg::IDX_PCR, 8'h20);
    chk({o_par_irq, o_par_irq_oe}, 16'h0003);
    w(iocfg_pkg::IDX_PTR, 8'h08);
    chk(o_par_cfg.irq7_sel, 16'h0001);
    i_par_func_en <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk({o_par_cfg.mode, o_par_cfg.access_en}, 16'h0000);
    i_par_func_en <= 1'b1;
    w(iocfg_pkg::IDX_PTR, 8'h10);
    {i_lcr7_1, i_uart1_sout} <= 2'h3;
    repeat (2) @(posedge i_clk);
    chk(o_serial1_out, 16'h0000);
    w(iocfg_pkg::IDX_PTR, 8'h01);
    chk({o_clocks_stop, o_crystal_stop}, 16'h0002);
    chk(o_ecp_clk_run, 16'h0000);
    w(iocfg_pkg::IDX_PTR, 8'h00);
    chk(o_func_ready, 16'h0001);
    w(iocfg_pkg::IDX_PTR, 8'h03);
    chk({o_crystal_stop, o_func_ready}, 16'h0002);
    w(iocfg_pkg::IDX_PTR, 8'h00);
    repeat (12) @(posedge i_clk);
    chk(o_func_ready, 16'h0000);
    for (int k = 0; k < 40 && o_func_ready !== 1'b1; k++) @(posedge i_clk);
    chk(o_func_ready, 16'h0001);
    w(iocfg_pkg::IDX_PMC, 8'h20);
    w(iocfg_pkg::IDX_FAR, 8'h00);
    chk(o_uart2_base, 16'h0228);
    w(iocfg_pkg::IDX_PTR, 8'h40);
    w(iocfg_pkg::IDX_FCR, 8'h00);
    r(iocfg_pkg::IDX_FCR, 8'hC0);
    r(iocfg_pkg::IDX_PTR, 8'h40);
    wrap_up();
  end
endmodule // iocfg_regs_test
`default_nettype wire
